// ---- design/sfrd_pkg.sv ----
// package of constants and carrier types for the serial flash read logic
package sfrd_pkg;
  localparam int          PAGE_COUNT     = 512;
  localparam int          PAGE_BYTES     = 264;
  localparam int          BUF_BYTES      = 264;
  localparam int          ARRAY_BYTES    = PAGE_COUNT * PAGE_BYTES;
  localparam int          ARR_AW         = 18;
  localparam int          BYTE_AW        = 9;
  localparam logic [8:0]  LAST_BYTE      = 9'h107;
  localparam logic [8:0]  LAST_PAGE      = 9'h1FF;
  localparam logic [7:0]  OP_ARRAY_MODE0 = 8'hE8;
  localparam logic [7:0]  OP_ARRAY_POL   = 8'h68;
  localparam logic [7:0]  OP_PAGE_MODE0  = 8'hD2;
  localparam logic [7:0]  OP_PAGE_POL    = 8'h52;
  localparam logic [7:0]  OP_BUF_MODE0   = 8'hD4;
  localparam logic [7:0]  OP_BUF_POL     = 8'h54;
  localparam logic [7:0]  OP_STAT_MODE0  = 8'hD7;
  localparam logic [7:0]  OP_STAT_POL    = 8'h57;
  localparam logic [6:0]  HDR_ARRAY_BITS = 7'h38;
  localparam logic [6:0]  HDR_BUF_BITS   = 7'h20;
  localparam int          PAGE_MSB       = 17;
  localparam int          PAGE_LSB       = 9;
  localparam logic [3:0]  DENSITY_CODE   = 4'h3;
  localparam logic [2:0]  STAT_LOW_BITS  = 3'h0;

  typedef enum logic [1:0] {SFRD_ARRAY, SFRD_PAGE, SFRD_BUF, SFRD_STAT} sfrd_cmd_t;

  typedef struct packed {
    logic        cs_n;
    logic        sck;
    logic        si;
  } sfrd_pins_t;

  typedef struct packed {
    logic        busy;
    logic        mismatch;
  } sfrd_stat_t;

  function automatic logic [8:0] sfrd_byte_next(input logic [8:0] b);
    return (b == LAST_BYTE) ? 9'h000 : b + 9'h001;
  endfunction
endpackage

// ---- design/sfrd_sync.sv ----
// two-flop synchroniser for the three serial input pins
`timescale 1ns/1ps
module sfrd_sync (
  // clock and control
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // pins in and synchronised out
  input  wire sfrd_pkg::sfrd_pins_t pins,
  output      sfrd_pkg::sfrd_pins_t pins_s
);
  import sfrd_pkg::*;
  sfrd_pins_t stage1;
  sfrd_pins_t next_stage1;
  sfrd_pins_t next_pins_s;

  always_comb begin
    next_stage1 = pins;
    next_pins_s = stage1;
  end

  // idle is deselected so a reset never looks like a falling select
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      pins_s <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end else if (ce) begin
      stage1 <= next_stage1;
      pins_s <= next_pins_s;
    end
  end
endmodule

// ---- design/sfrd_mem.sv ----
// byte memory with registered read and a write port for loading
`timescale 1ns/1ps
module sfrd_mem #(
  parameter int DEPTH = 264,
  parameter int AW    = 9
) (
  // clock
  input  wire logic          clk,
  input  wire logic          ce,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output      logic [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'hFF;
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rd_data <= next_rd_data;
      if (wr_en && int'(wr_addr) < DEPTH)
        mem[wr_addr] <= wr_data;
    end
  end
endmodule

// ---- design/sfrd_top.sv ----
// read-command engine of the serial flash: opcode decode, address, data streaming
`timescale 1ns/1ps
module sfrd_top (
  // clock and control
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // serial link pins, sampled on clk
  input  wire sfrd_pkg::sfrd_pins_t pins,
  output      logic                so,
  output      logic                so_oe,
  // device state shown in status
  input  wire sfrd_pkg::sfrd_stat_t stat,
  // preload ports for array and buffer contents
  input  wire logic                arr_wr_en,
  input  wire logic [17:0]         arr_wr_addr,
  input  wire logic                buf_wr_en,
  input  wire logic [8:0]          buf_wr_addr,
  input  wire logic [7:0]          ld_data
);
  import sfrd_pkg::*;

  typedef enum logic [2:0] {SFRD_IDLE, SFRD_OPC, SFRD_HDR, SFRD_DATA, SFRD_IGNORE} sfrd_state_t;

  sfrd_pins_t  pins_s;
  logic        cs_q;
  logic        sck_q;
  logic        stat_busy;
  logic        stat_mis;
  sfrd_state_t state;
  sfrd_state_t next_state;
  sfrd_cmd_t   cmd;
  sfrd_cmd_t   next_cmd;
  logic        mode0;
  logic        next_mode0;
  logic [6:0]  cnt;
  logic [6:0]  next_cnt;
  logic [31:0] shin;
  logic [31:0] next_shin;
  logic [8:0]  page;
  logic [8:0]  next_page;
  logic [8:0]  bidx;
  logic [8:0]  next_bidx;
  logic [2:0]  bitn;
  logic [2:0]  next_bitn;
  logic [7:0]  obyte;
  logic [7:0]  next_obyte;
  logic        load_pend;
  logic        next_load_pend;
  logic        next_so;
  logic        next_so_oe;
  logic [7:0]  arr_q;
  logic [7:0]  buf_q;
  logic [17:0] arr_rd_addr;
  logic [17:0] arr_wr_lin;
  logic [23:0] addr_in;
  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        shift_edge;
  logic [7:0]  opc;
  logic [7:0]  status_byte;

  // pages hold 264 bytes, so the flat index is a product rather than a concatenation
  function automatic logic [17:0] lin_addr(input logic [8:0] pg, input logic [8:0] b);
    return 18'(int'(pg) * PAGE_BYTES + int'(b));
  endfunction

  sfrd_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .pins   (pins),
    .pins_s (pins_s)
  );

  // array lives apart from the buffer; reads never write either
  sfrd_mem #(.DEPTH(ARRAY_BYTES), .AW(ARR_AW)) u_array (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (arr_wr_en),
    .wr_addr (arr_wr_lin),
    .wr_data (ld_data),
    .rd_addr (arr_rd_addr),
    .rd_data (arr_q)
  );

  // read address is the next index so the registered read is ready when load_pend asks
  sfrd_mem #(.DEPTH(BUF_BYTES), .AW(BYTE_AW)) u_buffer (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (buf_wr_en),
    .wr_addr (buf_wr_addr),
    .wr_data (ld_data),
    .rd_addr (next_bidx),
    .rd_data (buf_q)
  );

  // one cycle ahead, like the buffer, so a byte change never hands over stale data
  assign arr_rd_addr = lin_addr(next_page, next_bidx);
  assign arr_wr_lin  = lin_addr(arr_wr_addr[17:9], arr_wr_addr[8:0]);
  // the bit arriving now closes the 24-bit field; earlier bits sit behind it
  assign addr_in     = {shin[22:0], pins_s.si};
  assign rise        = pins_s.sck & ~sck_q;
  assign fall        = ~pins_s.sck & sck_q;
  assign cs_fall     = ~pins_s.cs_n & cs_q;
  assign cs_rise     = pins_s.cs_n & ~cs_q;
  // input sampled on rising edge in every mode, so idle level does not matter
  assign opc         = {shin[6:0], pins_s.si};
  // status fields sampled fresh each time bit 7 is loaded
  assign status_byte = {~stat_busy, stat_mis, DENSITY_CODE, STAT_LOW_BITS[1:0]};
  // mode-0 opcodes change output on falling edges, polarity opcodes on rising
  assign shift_edge  = mode0 ? fall : rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_q      <= 1'b1;
      sck_q     <= 1'b0;
      stat_busy <= 1'b0;
      stat_mis  <= 1'b0;
    end else if (ce) begin
      cs_q      <= pins_s.cs_n;
      sck_q     <= pins_s.sck;
      stat_busy <= stat.busy;
      stat_mis  <= stat.mismatch;
    end
  end

  always_comb begin
    next_state     = state;
    next_cmd       = cmd;
    next_mode0     = mode0;
    next_cnt       = cnt;
    next_shin      = shin;
    next_page      = page;
    next_bidx      = bidx;
    next_bitn      = bitn;
    next_obyte     = obyte;
    next_load_pend = 1'b0;
    next_so        = so;
    next_so_oe     = so_oe;
    if (load_pend) begin
      next_obyte = (cmd == SFRD_BUF) ? buf_q : arr_q;
      next_so    = next_obyte[7];
    end
    if (cs_rise || pins_s.cs_n) begin
      next_state = SFRD_IDLE;
      next_so_oe = 1'b0;
      next_so    = 1'b0;
    end else if (cs_fall) begin
      next_state = SFRD_OPC;
      next_cnt   = 7'h00;
      next_shin  = 32'h0000_0000;
    end else begin
      unique case (state)
        SFRD_IDLE, SFRD_IGNORE: ;
        SFRD_OPC: if (rise) begin
          next_shin = {shin[30:0], pins_s.si};
          next_cnt  = cnt + 7'h01;
          if (cnt == 7'h07) begin
            next_cnt   = 7'h00;
            next_state = SFRD_HDR;
            next_mode0 = opc[7];
            unique case (opc)
              OP_ARRAY_MODE0, OP_ARRAY_POL: next_cmd = SFRD_ARRAY;
              OP_PAGE_MODE0, OP_PAGE_POL:   next_cmd = SFRD_PAGE;
              OP_BUF_MODE0, OP_BUF_POL:     next_cmd = SFRD_BUF;
              OP_STAT_MODE0, OP_STAT_POL: begin
                next_cmd   = SFRD_STAT;
                next_state = SFRD_DATA;
                next_obyte = status_byte;
                next_bitn  = 3'h7;
                next_so_oe = 1'b1;
                next_so    = status_byte[7];
              end
              default: next_state = SFRD_IGNORE;
            endcase
          end
        end
        SFRD_HDR: if (rise) begin
          next_shin = {shin[30:0], pins_s.si};
          next_cnt  = cnt + 7'h01;
          // the 24th header bit ends the address field in every layout; latch it
          // there, since the trailing dummies would push it out of the shifter
          if (cnt == 7'h17) begin
            next_bidx = addr_in[BYTE_AW-1:0];
            if (cmd != SFRD_BUF) begin
              next_page = addr_in[PAGE_MSB:PAGE_LSB];
            end
          end
          if ((cmd != SFRD_BUF && cnt == HDR_ARRAY_BITS - 7'h01) ||
              (cmd == SFRD_BUF && cnt == HDR_BUF_BITS - 7'h01)) begin
            next_state     = SFRD_DATA;
            next_bitn      = 3'h7;
            next_so_oe     = 1'b1;
            next_load_pend = 1'b1;
          end
        end
        SFRD_DATA: if (shift_edge && !load_pend) begin
          next_bitn = bitn - 3'h1;
          next_so   = obyte[bitn - 3'h1];
          if (bitn == 3'h0) begin
            next_bitn = 3'h7;
            if (cmd == SFRD_STAT) begin
              next_obyte = status_byte;
              next_so    = status_byte[7];
            end else begin
              next_bidx      = sfrd_byte_next(bidx);
              next_load_pend = 1'b1;
              if (cmd == SFRD_ARRAY && bidx == LAST_BYTE) begin
                next_page = page + 9'h001;
              end
            end
          end
        end
        default: next_state = SFRD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= SFRD_IDLE;
      cmd       <= SFRD_STAT;
      mode0     <= 1'b0;
      cnt       <= 7'h00;
      shin      <= 32'h0000_0000;
      page      <= 9'h000;
      bidx      <= 9'h000;
      bitn      <= 3'h7;
      obyte     <= 8'h00;
      load_pend <= 1'b0;
      so        <= 1'b0;
      so_oe     <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      cmd       <= next_cmd;
      mode0     <= next_mode0;
      cnt       <= next_cnt;
      shin      <= next_shin;
      page      <= next_page;
      bidx      <= next_bidx;
      bitn      <= next_bitn;
      obyte     <= next_obyte;
      load_pend <= next_load_pend;
      so        <= next_so;
      so_oe     <= next_so_oe;
    end
  end

  chk_cs_float: assert property (@(posedge clk) disable iff (rst)
    ce && cs_rise |=> !so_oe) else $error("output still driven after deselect");
  chk_unknown_float: assert property (@(posedge clk) disable iff (rst)
    state == SFRD_IGNORE |-> !so_oe) else $error("unknown opcode drives output");
  chk_page_wrap: assert property (@(posedge clk) disable iff (rst)
    ce && cmd == SFRD_PAGE && state == SFRD_DATA && !cs_rise && !pins_s.cs_n
    |=> $stable(page)) else $error("page read left its page");
  chk_byte_range: assert property (@(posedge clk) disable iff (rst)
    bidx <= LAST_BYTE) else $error("byte index beyond 264");
  chk_array_roll: assert property (@(posedge clk) disable iff (rst)
    ce && cmd == SFRD_ARRAY && state == SFRD_DATA && shift_edge && !load_pend &&
    bitn == 3'h0 && bidx == LAST_BYTE && !cs_rise && !pins_s.cs_n
    |=> bidx == 9'h000 && page == $past(page) + 9'h001) else $error("no page rollover");
  chk_array_top: assert property (@(posedge clk) disable iff (rst)
    ce && cmd == SFRD_ARRAY && state == SFRD_DATA && shift_edge && !load_pend &&
    bitn == 3'h0 && bidx == LAST_BYTE && page == LAST_PAGE && !cs_rise && !pins_s.cs_n
    |=> page == 9'h000) else $error("array end did not wrap");
  chk_stat_first: assert property (@(posedge clk) disable iff (rst)
    ce && state == SFRD_OPC && rise && cnt == 7'h07 && !pins_s.cs_n && !cs_fall &&
    (opc == OP_STAT_MODE0 || opc == OP_STAT_POL)
    |=> so_oe && so == ~$past(stat_busy)) else $error("status bit 7 not first");
  chk_stat_low: assert property (@(posedge clk) disable iff (rst)
    cmd == SFRD_STAT && state == SFRD_DATA |-> obyte[5:2] == DENSITY_CODE)
    else $error("status info bits wrong");
  chk_oe_state: assert property (@(posedge clk) disable iff (rst)
    so_oe |-> state == SFRD_DATA) else $error("output driven outside data phase");
  // stream checks: where bit and byte boundaries must land, and that an ignored command stays quiet
  chk_stat_repeat: assert property (@(posedge clk) disable iff (rst)
    ce && cmd == SFRD_STAT && state == SFRD_DATA && shift_edge && !load_pend &&
    bitn == 3'h0 && !cs_rise && !pins_s.cs_n |=> bitn == 3'h7 && so == ~$past(stat_busy))
    else $error("status did not restart at bit 7");
  chk_buf_wrap: assert property (@(posedge clk) disable iff (rst)
    ce && cmd == SFRD_BUF && state == SFRD_DATA && shift_edge && !load_pend &&
    bitn == 3'h0 && bidx == LAST_BYTE && !cs_rise && !pins_s.cs_n |=> bidx == 9'h000)
    else $error("buffer read did not wrap");
  chk_page_byte: assert property (@(posedge clk) disable iff (rst)
    ce && cmd == SFRD_PAGE && state == SFRD_DATA && shift_edge && !load_pend &&
    bitn == 3'h0 && bidx == LAST_BYTE && !cs_rise && !pins_s.cs_n
    |=> bidx == 9'h000 && page == $past(page)) else $error("page read did not wrap in page");
  chk_mode_edge: assert property (@(posedge clk) disable iff (rst)
    ce && state == SFRD_DATA && (mode0 ? rise : fall) && !cs_rise && !pins_s.cs_n
    |=> $stable(bitn)) else $error("output shifted on the wrong clock edge");
  chk_ignore_hold: assert property (@(posedge clk) disable iff (rst)
    ce && state == SFRD_IGNORE && !cs_rise && !pins_s.cs_n
    |=> state == SFRD_IGNORE && !so_oe) else $error("ignored command left its wait");
  chk_hdr_len: assert property (@(posedge clk) disable iff (rst)
    ce && state == SFRD_HDR && cmd != SFRD_BUF && rise && cnt == HDR_ARRAY_BITS - 7'h01 &&
    !cs_rise && !pins_s.cs_n |=> state == SFRD_DATA && so_oe)
    else $error("array header length wrong");

  // scenario coverage, one per command kind plus one for an ignored opcode
  cov_array: cover property (@(posedge clk) cmd == SFRD_ARRAY && state == SFRD_DATA);
  cov_buf: cover property (@(posedge clk) cmd == SFRD_BUF && state == SFRD_DATA);
  cov_stat: cover property (@(posedge clk) cmd == SFRD_STAT && state == SFRD_DATA);
  cov_ign: cover property (@(posedge clk) state == SFRD_IGNORE);
  cov_page: cover property (@(posedge clk) cmd == SFRD_PAGE && state == SFRD_DATA);
endmodule

// ---- tb/sfrd_host.sv ----
// host-side serial master model for the flash read link
`timescale 1ns/1ps
module sfrd_host (
  // clock
  input  wire logic                 clk,
  // link
  output      sfrd_pkg::sfrd_pins_t pins,
  input  wire logic                 so,
  input  wire logic                 so_oe
);
  import sfrd_pkg::*;
  localparam int HALF = 8;
  logic [7:0] rx [0:7];
  logic       oe_early;
  logic       oe_seen;
  logic       hdr;
  logic       hdr_en;

  initial begin
    pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    hdr  = 1'b0;
    hdr_en = 1'b0;
  end

  always @(posedge clk) begin
    if (hdr && so_oe === 1'b1) oe_early <= 1'b1;
    if (so_oe === 1'b1) oe_seen <= 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // si changes only in the low phase, so the device sees it settled at the rise
  task automatic put_bit(input logic b);
    pins.sck = 1'b0;
    pins.si  = b;
    hdr      = hdr_en;
    wait_clk(HALF);
    hdr      = 1'b0;
    pins.sck = 1'b1;
    wait_clk(HALF);
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] fld, input int nf,
                       input int nd, input int nbytes, input logic idle_hi);
    oe_early = 1'b0;
    oe_seen  = 1'b0;
    pins.sck = idle_hi;
    wait_clk(HALF);
    pins.cs_n = 1'b0;
    wait_clk(HALF);
    hdr_en = 1'b1;
    for (int i = 7; i >= 0; i--) put_bit(op[i]);
    for (int i = nf - 1; i >= 0; i--) put_bit(fld[i]);
    for (int i = 0; i < nd; i++) put_bit(i[0]);
    hdr_en = 1'b0;
    for (int k = 0; k < nbytes; k++) begin
      for (int i = 7; i >= 0; i--) begin
        // sampled just before the fall; an undriven line reads inverted so a lost enable shows
        rx[k][i] = so_oe ? so : ~so;
        put_bit(~rx[k][i]);
      end
    end
    pins.sck = idle_hi;
    wait_clk(HALF);
    pins.cs_n = 1'b1;
    wait_clk(2 * HALF);
  endtask
endmodule

// ---- tb/sfrd_top_test.sv ----
// self-checking bench for the serial flash read engine
`timescale 1ns/1ps
module sfrd_top_test;
  import sfrd_pkg::*;
  logic       clk;
  logic       rst;
  logic       ce;
  sfrd_pins_t pins;
  logic       so;
  logic       so_oe;
  sfrd_stat_t stat;
  logic       arr_wr_en;
  logic [17:0] arr_wr_addr;
  logic       buf_wr_en;
  logic [8:0] buf_wr_addr;
  logic [7:0] ld_data;
  int         err_count;
  int         checked;
  logic [17:0] alist [8] = '{18'h3FF06, 18'h3FF07, 18'h00000, 18'h00001,
                             18'h00B07, 18'h00C00, 18'h00F07, 18'h00E00};

  sfrd_top sfrd_top_inst (
    .clk(clk), .rst(rst), .ce(ce), .pins(pins), .so(so), .so_oe(so_oe),
    .stat(stat), .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr),
    .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr), .ld_data(ld_data)
  );

  sfrd_host sfrd_host_inst (.clk(clk), .pins(pins), .so(so), .so_oe(so_oe));

  function automatic logic [7:0] apat(input logic [8:0] pg, input logic [8:0] b);
    return b[7:0] ^ {pg[6:0], b[8]};
  endfunction

  function automatic logic [7:0] bpat(input logic [8:0] b);
    return 8'h5A ^ b[7:0] ^ {b[8], 7'h00};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic load(input logic arr, input logic [17:0] a, input logic [7:0] d);
    arr_wr_en   = arr;
    buf_wr_en   = ~arr;
    arr_wr_addr = a;
    buf_wr_addr = a[8:0];
    ld_data     = d;
    @(posedge clk);
    #1;
  endtask

  // kind 0 array, 1 page, 2 buffer
  task automatic t_read(input logic [7:0] op, input logic [8:0] pg, input logic [8:0] b,
                        input int kind, input int n, input logic idle_hi);
    logic [23:0] fld;
    logic [7:0]  exp;
    // reserved bits sent as ones and dummy bits as alternating zeros and ones, the device must ignore them
    fld = (kind == 2) ? {15'h7FFF, b} : {6'h3F, pg, b};
    sfrd_host_inst.frame(op, fld, 24, (kind == 2) ? 8 : 32, n, idle_hi);
    chk("output during header", 8'h00, {7'h00, sfrd_host_inst.oe_early});
    for (int k = 0; k < n; k++) begin
      exp = (kind == 2) ? bpat(b) : apat(pg, b);
      chk("read byte", exp, sfrd_host_inst.rx[k]);
      if (b == LAST_BYTE && kind == 0) pg = pg + 9'h001;
      b = (b == LAST_BYTE) ? 9'h000 : b + 9'h001;
    end
    chk("oe after select rise", 8'h00, {7'h00, so_oe});
  endtask

  task automatic t_array();
    t_read(OP_ARRAY_MODE0, LAST_PAGE, 9'h106, 0, 4, 1'b0);
    t_read(OP_ARRAY_POL, 9'h005, LAST_BYTE, 0, 2, 1'b1);
    $display("test array done");
  endtask

  task automatic t_page();
    t_read(OP_PAGE_MODE0, 9'h007, LAST_BYTE, 1, 2, 1'b1);
    t_read(OP_PAGE_POL, 9'h007, LAST_BYTE, 1, 2, 1'b0);
    $display("test page done");
  endtask

  // runs after the array and page reads, so it also shows the buffer survived them
  task automatic t_buf();
    t_read(OP_BUF_MODE0, 9'h000, 9'h106, 2, 4, 1'b0);
    t_read(OP_BUF_POL, 9'h000, LAST_BYTE, 2, 2, 1'b1);
    $display("test buffer done");
  endtask

  task automatic t_status();
    stat = '{busy: 1'b1, mismatch: 1'b0};
    fork
      sfrd_host_inst.frame(OP_STAT_MODE0, 24'h0, 0, 0, 2, 1'b0);
      begin
        repeat (200) @(posedge clk);
        #1;
        stat = '{busy: 1'b0, mismatch: 1'b1};
      end
    join
    chk("status busy", {4'h0, DENSITY_CODE}, {2'h0, sfrd_host_inst.rx[0][7:2]});
    chk("status fresh", {4'h3, DENSITY_CODE}, {2'h0, sfrd_host_inst.rx[1][7:2]});
    sfrd_host_inst.frame(OP_STAT_POL, 24'h0, 0, 0, 1, 1'b1);
    chk("status pol", {4'h3, DENSITY_CODE}, {2'h0, sfrd_host_inst.rx[0][7:2]});
    $display("test status done");
  endtask

  task automatic t_abort();
    sfrd_host_inst.frame(8'h0F, 24'h0, 0, 0, 2, 1'b0);
    chk("unknown opcode oe", 8'h00, {7'h00, sfrd_host_inst.oe_seen});
    sfrd_host_inst.frame(OP_ARRAY_MODE0, 24'h0, 24, 32, 0, 1'b1);
    chk("oe before abort", 8'h01, {7'h00, sfrd_host_inst.oe_seen});
    chk("oe after abort", 8'h00, {7'h00, so_oe});
    $display("test abort done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    stat = '{busy: 1'b0, mismatch: 1'b0};
    arr_wr_en = 1'b0;
    arr_wr_addr = '0;
    buf_wr_en = 1'b0;
    buf_wr_addr = '0;
    ld_data = '0;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (alist[i]) load(1'b1, alist[i], apat(alist[i][17:9], alist[i][8:0]));
    foreach (alist[i]) load(1'b0, alist[i], bpat(alist[i][8:0]));
    arr_wr_en = 1'b0;
    buf_wr_en = 1'b0;
    t_array();
    t_page();
    t_buf();
    t_status();
    t_abort();
    end_sim();
  end

  // watchdog: the whole sequence needs far fewer cycles than this
  initial begin
    repeat (40000) @(posedge clk);
    $display("CHECK FAILED watchdog expected finish seen hang");
    err_count++;
    end_sim();
  end
endmodule
